// *** include/tcrf_defines.vh ***
// Constants of the temperature-control remote flag block.
// Assumes APB 32-bit data; register index times four is the byte address.
// Behaviour
// - Tuning-active flag high during program auto tuning or device self-tuning, else low.
// - Auto-tuning request starts tuning; flag stays high, self-clears on completion.
// - Flag rises when self-tuning begins and drops when it ends.
// - Ch3/ch4 flags only in expanded heat-cool; ch2 in mixed only expanded.
// - Self-tuning runs only in standard control mode.
// - Self-tuning start condition comes from the channel's self-tune setting word.
// - Simultaneous-rise flag high while the channel heats in the grouped rise.
// - Rise flag clears when the grouped phase ends, not at rise completion.
// - Offset-latch-done sets on offset store, clears when its request drops.
// - Gain-latch-done sets on gain store, clears when its request drops.
// - Output and ON-delay flags mirror outputs; second group for cooling output.
// - ON-delay flag follows output flag delayed by the programmed ON-delay time.
// - Accepted init request applies parameters, then done flag when condition changes.
// - Init request while any channel operates is rejected with error 0003H.
// - Error-clear on then off drops error flag for 0003H/FFFFH and 0006H.
// - Error clear keeps history; only the history-clear command erases it.
// - Remote ready is low whenever the error flag is set.
// - Dropping the tuning request aborts tuning, PID constants stay unchanged.
`ifndef TCRF_DEFINES_VH
`define TCRF_DEFINES_VH
`define TCRF_IDX_ON_DELAY    16'h01ea
`define TCRF_IDX_ST_CH1      16'h02c0
`define TCRF_IDX_ST_CH4      16'h02c3
`define TCRF_IDX_HIST_CLR    16'h1000
`define TCRF_IDX_ERR_CODE    16'h0700
`define TCRF_IDX_ERR_ADDR    16'h0701
`define TCRF_IDX_HIST_CNT    16'h0702
`define TCRF_IDX_FLAGS       16'h0703
`define TCRF_MODE_STD        2'h0
`define TCRF_MODE_HC         2'h1
`define TCRF_MODE_MIX        2'h2
`define TCRF_ERR_INIT        16'h0003
`define TCRF_ERR_SETTING     16'h0006
`define TCRF_ADDR_NONE       16'hffff
`define TCRF_HIST_CLR_CMD    16'h0001
`define TCRF_ST_ENABLE_BIT   0
`define TCRF_ST_IDLE         2'h0
`define TCRF_ST_APPLY        2'h1
`define TCRF_ST_DONE         2'h2
`define TCRF_ZERO16          16'h0000
`define TCRF_ZERO32          32'h0000_0000
`endif

// *** src/tcrf_top.v ***
// Remote status/request flag logic of a four-channel temperature controller.
// Assumes the control core reports tuning, rise, latch and output events as
// synchronous one-cycle pulses or levels on clk_sys.
`include "tcrf_defines.vh"
`default_nettype none
module tcrf_top #(
    parameter NCH          = 4,
    parameter UNIT_CYCLES  = 200000
) (
    input  wire                clk_sys,
    input  wire                rst,
    input  wire                ce,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [15:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    input  wire [1:0]          ctrl_mode,
    input  wire                expanded_mode,
    input  wire [NCH-1:0]      ch_operating,
    input  wire [NCH-1:0]      tuning_request,
    input  wire [NCH-1:0]      tune_complete,
    input  wire [NCH-1:0]      self_tune_begin,
    input  wire [NCH-1:0]      self_tune_end,
    input  wire [NCH-1:0]      group_rise_phase,
    input  wire [NCH-1:0]      offset_latch_request,
    input  wire [NCH-1:0]      offset_stored,
    input  wire [NCH-1:0]      gain_latch_request,
    input  wire [NCH-1:0]      gain_stored,
    input  wire [NCH-1:0]      output_state,
    input  wire [NCH-1:0]      second_output_state,
    input  wire                init_setting_request,
    input  wire                cond_changed,
    input  wire                error_clear_request,
    input  wire                error_event,
    input  wire [15:0]         error_event_code,
    input  wire [15:0]         error_event_addr,
    output reg  [NCH-1:0]      tuning_active_flag,
    output reg  [NCH-1:0]      pid_commit,
    output reg  [NCH-1:0]      simul_rise_active_flag,
    output reg  [NCH-1:0]      offset_latch_done_flag,
    output reg  [NCH-1:0]      gain_latch_done_flag,
    output reg  [NCH-1:0]      output_state_flag,
    output reg  [NCH-1:0]      delayed_output_flag,
    output reg  [NCH-1:0]      second_output_state_flag,
    output reg  [NCH-1:0]      second_delayed_output_flag,
    output reg                 params_apply,
    output reg                 init_setting_done_flag,
    output reg                 error_flag,
    output wire                remote_ready_flag
);
    reg  [15:0]      on_delay_ff;
    reg  [15:0]      st_set_ff [0:NCH-1];
    reg  [15:0]      hist_clr_ff;
    reg  [15:0]      err_code_ff;
    reg  [15:0]      err_addr_ff;
    reg  [15:0]      hist_cnt_ff;
    reg  [NCH-1:0]   at_run_ff;
    reg  [NCH-1:0]   st_run_ff;
    reg  [NCH-1:0]   treq_d_ff;
    reg              ireq_d_ff;
    reg              eclr_d_ff;
    reg  [1:0]       init_st_ff;
    reg  [1:0]       nxt_init_st;
    reg  [31:0]      tick_cnt_ff;
    reg              tick_ff;
    reg  [31:0]      rd_mux;
    reg              rd_hit;
    reg  [NCH-1:0]   avail;

    wire [15:0] idx     = {2'b00, paddr[15:2]};
    wire        acc     = psel & penable;
    wire        wr_acc  = acc & pwrite & ce;
    wire        st_hit  = (idx >= `TCRF_IDX_ST_CH1) && (idx <= `TCRF_IDX_ST_CH4);
    wire [1:0]  st_sel  = idx[1:0];
    wire        std_md  = (ctrl_mode == `TCRF_MODE_STD);
    wire        ireq_rise = init_setting_request & ~ireq_d_ff;
    wire        init_reject = ireq_rise & (|ch_operating);
    // Clear only on the falling half of an on-off pulse of the request
    wire        eclr_fall = eclr_d_ff & ~error_clear_request;
    wire        err_clearable = ((err_code_ff == `TCRF_ERR_INIT) &&
                                 (err_addr_ff == `TCRF_ADDR_NONE)) ||
                                (err_code_ff == `TCRF_ERR_SETTING);
    wire        hist_clr = wr_acc && (idx == `TCRF_IDX_HIST_CLR) &&
                           (pwdata[15:0] == `TCRF_HIST_CLR_CMD);

    // Zero-wait slave: read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = acc & ~rd_hit;
    assign remote_ready_flag = ~error_flag;

    integer i;
    always @* begin
        for (i = 0; i < NCH; i = i + 1) begin
            avail[i] = 1'b1;
        end
        if (!expanded_mode && ctrl_mode == `TCRF_MODE_HC) begin
            avail[2] = 1'b0;
            avail[3] = 1'b0;
        end
        if (!expanded_mode && ctrl_mode == `TCRF_MODE_MIX) begin
            avail[1] = 1'b0;
        end
    end

    always @* begin
        rd_hit = 1'b1;
        rd_mux = `TCRF_ZERO32;
        if (idx == `TCRF_IDX_ON_DELAY) begin
            rd_mux = {16'h0000, on_delay_ff};
        end else if (st_hit) begin
            rd_mux = {16'h0000, st_set_ff[st_sel]};
        end else if (idx == `TCRF_IDX_HIST_CLR) begin
            rd_mux = {16'h0000, hist_clr_ff};
        end else if (idx == `TCRF_IDX_ERR_CODE) begin
            rd_mux = {16'h0000, err_code_ff};
        end else if (idx == `TCRF_IDX_ERR_ADDR) begin
            rd_mux = {16'h0000, err_addr_ff};
        end else if (idx == `TCRF_IDX_HIST_CNT) begin
            rd_mux = {16'h0000, hist_cnt_ff};
        end else if (idx == `TCRF_IDX_FLAGS) begin
            rd_mux = {16'h0000, tuning_active_flag, simul_rise_active_flag,
                      offset_latch_done_flag, gain_latch_done_flag};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Register file and bus read data
    integer k;
    always @(posedge clk_sys) begin
        if (rst) begin
            prdata      <= `TCRF_ZERO32;
            on_delay_ff <= `TCRF_ZERO16;
            hist_clr_ff <= `TCRF_ZERO16;
            for (k = 0; k < NCH; k = k + 1) begin
                st_set_ff[k] <= `TCRF_ZERO16;
            end
        end else if (ce) begin
            if (psel && !penable) begin
                prdata <= rd_mux;
            end
            if (wr_acc && idx == `TCRF_IDX_ON_DELAY) begin
                on_delay_ff <= pwdata[15:0];
            end
            if (wr_acc && st_hit) begin
                st_set_ff[st_sel] <= pwdata[15:0];
            end
            if (wr_acc && idx == `TCRF_IDX_HIST_CLR) begin
                hist_clr_ff <= pwdata[15:0];
            end
        end
    end

    // Shared time base for the ON-delay counters
    always @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_ff <= `TCRF_ZERO32;
            tick_ff     <= 1'b0;
        end else if (ce) begin
            tick_ff <= (tick_cnt_ff == UNIT_CYCLES - 1);
            if (tick_cnt_ff == UNIT_CYCLES - 1) begin
                tick_cnt_ff <= `TCRF_ZERO32;
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            end
        end
    end

    // Per-channel flags; each channel sees only its own inputs
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gen_ch
            reg [15:0] dly1_ff;
            reg [15:0] dly2_ff;
            always @(posedge clk_sys) begin
                if (rst) begin
                    at_run_ff[g]                  <= 1'b0;
                    st_run_ff[g]                  <= 1'b0;
                    treq_d_ff[g]                  <= 1'b0;
                    pid_commit[g]                 <= 1'b0;
                    tuning_active_flag[g]         <= 1'b0;
                    simul_rise_active_flag[g]     <= 1'b0;
                    offset_latch_done_flag[g]     <= 1'b0;
                    gain_latch_done_flag[g]       <= 1'b0;
                    output_state_flag[g]          <= 1'b0;
                    second_output_state_flag[g]   <= 1'b0;
                    delayed_output_flag[g]        <= 1'b0;
                    second_delayed_output_flag[g] <= 1'b0;
                    dly1_ff                       <= `TCRF_ZERO16;
                    dly2_ff                       <= `TCRF_ZERO16;
                end else if (ce) begin
                    treq_d_ff[g] <= tuning_request[g];
                    pid_commit[g] <= 1'b0;
                    // Auto tuning: start on request edge, end on completion
                    if (!tuning_request[g]) begin
                        at_run_ff[g] <= 1'b0;
                    end else if (at_run_ff[g] && tune_complete[g]) begin
                        at_run_ff[g]  <= 1'b0;
                        pid_commit[g] <= 1'b1;
                    end else if (!treq_d_ff[g]) begin
                        at_run_ff[g] <= 1'b1;
                    end
                    // Self-tuning, only in standard mode with enabled setting
                    if (!std_md) begin
                        st_run_ff[g] <= 1'b0;
                    end else if (self_tune_begin[g] &&
                                 st_set_ff[g][`TCRF_ST_ENABLE_BIT]) begin
                        st_run_ff[g] <= 1'b1;
                    end else if (self_tune_end[g]) begin
                        st_run_ff[g] <= 1'b0;
                    end
                    tuning_active_flag[g] <= avail[g] &
                        (nxt_run_at(g) | nxt_run_st(g));
                    // Grouped rise only; rise completion alone does not end it
                    simul_rise_active_flag[g] <= group_rise_phase[g];
                    if (offset_stored[g]) begin
                        offset_latch_done_flag[g] <= 1'b1;
                    end else if (!offset_latch_request[g]) begin
                        offset_latch_done_flag[g] <= 1'b0;
                    end
                    if (gain_stored[g]) begin
                        gain_latch_done_flag[g] <= 1'b1;
                    end else if (!gain_latch_request[g]) begin
                        gain_latch_done_flag[g] <= 1'b0;
                    end
                    output_state_flag[g]        <= output_state[g];
                    second_output_state_flag[g] <= second_output_state[g];
                    // ON edge waits the programmed units, OFF edge is immediate
                    if (!output_state_flag[g]) begin
                        dly1_ff                <= `TCRF_ZERO16;
                        delayed_output_flag[g] <= 1'b0;
                    end else if (dly1_ff >= on_delay_ff) begin
                        delayed_output_flag[g] <= 1'b1;
                    end else if (tick_ff) begin
                        dly1_ff <= dly1_ff + 16'h0001;
                    end
                    if (!second_output_state_flag[g]) begin
                        dly2_ff                       <= `TCRF_ZERO16;
                        second_delayed_output_flag[g] <= 1'b0;
                    end else if (dly2_ff >= on_delay_ff) begin
                        second_delayed_output_flag[g] <= 1'b1;
                    end else if (tick_ff) begin
                        dly2_ff <= dly2_ff + 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // Next tuning state of a channel, so the flag tracks it without a lag
    function nxt_run_at;
        input integer c;
        begin
            nxt_run_at = tuning_request[c] &
                         ((at_run_ff[c] & ~tune_complete[c]) | ~treq_d_ff[c]);
        end
    endfunction

    function nxt_run_st;
        input integer c;
        begin
            nxt_run_st = std_md & ((self_tune_begin[c] &
                         st_set_ff[c][`TCRF_ST_ENABLE_BIT]) |
                         (st_run_ff[c] & ~self_tune_end[c]));
        end
    endfunction

    // Initial-setting handshake; relies on the master stopping channels first
    always @* begin
        nxt_init_st = init_st_ff;
        case (init_st_ff)
            `TCRF_ST_IDLE: begin
                if (ireq_rise && !init_reject) begin
                    nxt_init_st = `TCRF_ST_APPLY;
                end
            end
            `TCRF_ST_APPLY: begin
                if (!init_setting_request) begin
                    nxt_init_st = `TCRF_ST_IDLE;
                end else if (cond_changed) begin
                    nxt_init_st = `TCRF_ST_DONE;
                end
            end
            `TCRF_ST_DONE: begin
                if (!init_setting_request) begin
                    nxt_init_st = `TCRF_ST_IDLE;
                end
            end
            default: nxt_init_st = `TCRF_ST_IDLE;
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            init_st_ff             <= `TCRF_ST_IDLE;
            ireq_d_ff              <= 1'b0;
            eclr_d_ff              <= 1'b0;
            params_apply           <= 1'b0;
            init_setting_done_flag <= 1'b0;
            error_flag             <= 1'b0;
            err_code_ff            <= `TCRF_ZERO16;
            err_addr_ff            <= `TCRF_ZERO16;
            hist_cnt_ff            <= `TCRF_ZERO16;
        end else if (ce) begin
            init_st_ff   <= nxt_init_st;
            ireq_d_ff    <= init_setting_request;
            eclr_d_ff    <= error_clear_request;
            params_apply <= (init_st_ff == `TCRF_ST_IDLE) &&
                            (nxt_init_st == `TCRF_ST_APPLY);
            init_setting_done_flag <= (nxt_init_st == `TCRF_ST_DONE);
            // A new error wins over a clear in the same cycle
            if (init_reject) begin
                error_flag  <= 1'b1;
                err_code_ff <= `TCRF_ERR_INIT;
                err_addr_ff <= `TCRF_ADDR_NONE;
            end else if (error_event) begin
                error_flag  <= 1'b1;
                err_code_ff <= error_event_code;
                err_addr_ff <= error_event_addr;
            end else if (eclr_fall && err_clearable) begin
                error_flag <= 1'b0;
            end
            // History survives error clear; only the command erases it
            if (init_reject || error_event) begin
                hist_cnt_ff <= hist_cnt_ff + 16'h0001;
            end else if (hist_clr) begin
                hist_cnt_ff <= `TCRF_ZERO16;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tcrf_checker.sv ***
// Concurrent checks on the ports of the remote flag block.
// Assumes a bind to tcrf_top; the bench keeps ce high throughout.
`include "tcrf_defines.vh"
`default_nettype none
module tcrf_checker #(
    parameter NCH         = 4,
    parameter UNIT_CYCLES = 200000
) (
    input wire logic           clk_sys,
    input wire logic           rst,
    input wire logic           ce,
    input wire logic [1:0]     ctrl_mode,
    input wire logic [NCH-1:0] ch_operating,
    input wire logic [NCH-1:0] tuning_request,
    input wire logic [NCH-1:0] tune_complete,
    input wire logic [NCH-1:0] group_rise_phase,
    input wire logic [NCH-1:0] offset_stored,
    input wire logic [NCH-1:0] gain_latch_request,
    input wire logic [NCH-1:0] gain_stored,
    input wire logic           init_setting_request,
    input wire logic [NCH-1:0] tuning_active_flag,
    input wire logic [NCH-1:0] pid_commit,
    input wire logic [NCH-1:0] simul_rise_active_flag,
    input wire logic [NCH-1:0] offset_latch_done_flag,
    input wire logic [NCH-1:0] gain_latch_done_flag,
    input wire logic [NCH-1:0] output_state_flag,
    input wire logic [NCH-1:0] delayed_output_flag,
    input wire logic           params_apply,
    input wire logic           error_flag,
    input wire logic           remote_ready_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    // Frozen state under ce low would break every timing relation
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || !ce);
    ready_inv_a: assert property (remote_ready_flag == !error_flag)
        else $error("ready not inverse of error");
    rise_track_a: assert property (simul_rise_active_flag == $past(group_rise_phase))
        else $error("rise flag wrong");
    tune_start_a: assert property ($rose(tuning_request[0]) |=> tuning_active_flag[0])
        else $error("tuning flag did not rise on request");
    tune_end_a: assert property (tuning_active_flag[0] && tune_complete[0]
        |=> !tuning_active_flag[0] && pid_commit[0]) else $error("tuning end mishandled");
    tune_abort_a: assert property (tuning_active_flag[0] && $fell(tuning_request[0])
        && !tune_complete[0] |=> !tuning_active_flag[0] && !pid_commit[0])
        else $error("aborted tuning still active or committed");
    self_mode_a: assert property (ctrl_mode != `TCRF_MODE_STD && !tuning_request[0]
        && !tuning_active_flag[0] |=> !tuning_active_flag[0]) else $error("self-tune outside std");
    offset_set_a: assert property (offset_stored[0] |=> offset_latch_done_flag[0])
        else $error("offset latch done not set");
    gain_clr_a: assert property (!gain_latch_request[0] && !gain_stored[0]
        |=> !gain_latch_done_flag[0]) else $error("gain latch done not cleared");
    init_rej_a: assert property ($rose(init_setting_request) && (|ch_operating)
        |=> error_flag && !params_apply) else $error("init request not rejected");
    init_ok_a: assert property ($rose(init_setting_request) && !(|ch_operating)
        |=> params_apply ##1 !params_apply) else $error("init apply pulse wrong");
    delay_low_a: assert property (!output_state_flag[0] [*2] |-> !delayed_output_flag[0])
        else $error("delayed flag high without output");
    cover property ($rose(params_apply));
    cover property (pid_commit[0]);
    cover property ($fell(error_flag));
    cover property ($rose(delayed_output_flag[0]));
endmodule
bind tcrf_top tcrf_checker #(.NCH(NCH), .UNIT_CYCLES(UNIT_CYCLES)) i_tcrf_checker (.*);
`default_nettype wire

// *** tb/tcrf_master_model.sv ***
// Master station side of the two-point correction latch handshake.
// Assumes the bench pulses start per channel; HOLD sets how slowly it answers.
`default_nettype none
module tcrf_master_model #(
    parameter int HOLD = 3
) (
    input wire logic  clk_sys,
    input wire logic  rst,
    input wire logic  [3:0] start,
    input wire logic  [3:0] offset_latch_done_flag,
    input wire logic  [3:0] gain_latch_done_flag,
    output var logic  [3:0] offset_latch_request,
    output var logic  [3:0] gain_latch_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wait_cnt [4];
    // Request drops only after both done flags were seen for HOLD+1 cycles
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                offset_latch_request[i] <= 1'b0;
                gain_latch_request[i] <= 1'b0;
                wait_cnt[i] <= 8'h00;
            end else if (start[i]) begin
                offset_latch_request[i] <= 1'b1;
                gain_latch_request[i] <= 1'b1;
                wait_cnt[i] <= 8'h00;
            end else if (offset_latch_done_flag[i] && gain_latch_done_flag[i]) begin
                wait_cnt[i] <= wait_cnt[i] + 8'h01;
                if (wait_cnt[i] == HOLD[7:0]) begin
                    offset_latch_request[i] <= 1'b0;
                    gain_latch_request[i] <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the remote flag block over APB and flag ports.
// Assumes tcrf_top with UNIT_CYCLES shortened to 4 and a 200 MHz clock.
`include "tcrf_defines.vh"
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, expanded_mode = 0;
    logic init_setting_request = 0, cond_changed = 0, error_clear_request = 0, error_event = 0;
    logic [15:0] paddr = 0, error_event_code = 0, error_event_addr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0]  ctrl_mode = 0;
    logic [3:0]  ch_operating = 0, tuning_request = 0, tune_complete = 0, self_tune_begin = 0;
    logic [3:0]  self_tune_end = 0, group_rise_phase = 0, offset_stored = 0, gain_stored = 0;
    logic [3:0]  output_state = 0, second_output_state = 0, start = 0;
    logic pready, pslverr, params_apply, init_setting_done_flag, error_flag, remote_ready_flag;
    logic err, acc;
    logic [3:0]  tuning_active_flag, pid_commit, simul_rise_active_flag, offset_latch_done_flag;
    logic [3:0]  gain_latch_done_flag, output_state_flag, delayed_output_flag;
    logic [3:0]  second_output_state_flag, second_delayed_output_flag;
    logic [3:0]  offset_latch_request, gain_latch_request;
    logic [3:0]  exp_m [4] = '{4'h3, 4'hf, 4'hd, 4'hf};
    int miscompares = 0, compares = 0, n;
    // Every port has a bench signal of the same name
    tcrf_top #(.NCH(4), .UNIT_CYCLES(4)) i_tcrf_top (.*);
    tcrf_master_model #(.HOLD(3)) i_tcrf_master_model (.*);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // Entered just after an edge; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rchk(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, e)
    endtask
    task test_done;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        cyc(4000);
        miscompares++;
        test_done;
    end
    initial begin
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        `CHK({remote_ready_flag, error_flag, tuning_active_flag,
              delayed_output_flag}, 10'h200)
        rchk(16'h1c0c, 32'h0000_0000);
        apb(1'b1, 16'h07a8, 32'h0000_0002);
        rchk(16'h07a8, 32'h0000_0002);
        apb(1'b1, 16'h0b00, 32'h0000_0001);
        apb(1'b1, 16'h0b04, 32'h0000_0000);
        apb(1'b0, 16'h0004, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        tuning_request <= 4'h1;
        cyc(2);
        `CHK(tuning_active_flag, 4'h1)
        tune_complete <= 4'h1;
        cyc(1);
        tune_complete <= 4'h0;
        cyc(1);
        `CHK({tuning_active_flag, pid_commit}, 8'h01)
        tuning_request <= 4'h0;
        cyc(1);
        tuning_request <= 4'h1;
        cyc(2);
        tuning_request <= 4'h0;
        cyc(2);
        `CHK({tuning_active_flag, pid_commit}, 8'h00)
        for (int i = 0; i < 4; i++) begin
            ctrl_mode <= i[1] ? `TCRF_MODE_MIX : `TCRF_MODE_HC;
            expanded_mode <= i[0];
            tuning_request <= 4'hf;
            cyc(2);
            `CHK(tuning_active_flag, exp_m[i])
            tuning_request <= 4'h0;
            cyc(2);
        end
        self_tune_begin <= 4'h1;
        cyc(1);
        self_tune_begin <= 4'h0;
        cyc(1);
        `CHK(tuning_active_flag, 4'h0)
        ctrl_mode <= `TCRF_MODE_STD;
        self_tune_begin <= 4'h3;
        cyc(1);
        self_tune_begin <= 4'h0;
        cyc(1);
        `CHK(tuning_active_flag, 4'h1)
        self_tune_end <= 4'h1;
        cyc(1);
        self_tune_end <= 4'h0;
        cyc(1);
        `CHK(tuning_active_flag, 4'h0)
        group_rise_phase <= 4'h6;
        cyc(2);
        `CHK(simul_rise_active_flag, 4'h6)
        group_rise_phase <= 4'h2;
        cyc(2);
        `CHK(simul_rise_active_flag, 4'h2)
        group_rise_phase <= 4'h0;
        start <= 4'h4;
        cyc(1);
        start <= 4'h0;
        offset_stored <= 4'h4;
        gain_stored <= 4'h4;
        cyc(1);
        offset_stored <= 4'h0;
        gain_stored <= 4'h0;
        cyc(1);
        `CHK({offset_latch_done_flag, gain_latch_done_flag}, 8'h44)
        n = 0;
        while (offset_latch_request !== 4'h0 && n < 50) begin
            cyc(1);
            n++;
        end
        cyc(2);
        `CHK({offset_latch_done_flag, gain_latch_done_flag}, 8'h00)
        output_state <= 4'h1;
        second_output_state <= 4'h1;
        n = 0;
        while (delayed_output_flag[0] !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
        `CHK(n >= 8 && n <= 13, 1'b1)
        `CHK({output_state_flag, second_output_state_flag,
              second_delayed_output_flag}, 12'h111)
        output_state <= 4'h0;
        second_output_state <= 4'h0;
        cyc(3);
        `CHK({delayed_output_flag, second_delayed_output_flag}, 8'h00)
        output_state <= 4'h1;
        cyc(3);
        output_state <= 4'h0;
        acc = 1'b0;
        repeat (15) begin
            cyc(1);
            acc = acc | delayed_output_flag[0];
        end
        `CHK(acc, 1'b0)
        init_setting_request <= 1'b1;
        cyc(2);
        `CHK(params_apply, 1'b1)
        cond_changed <= 1'b1;
        cyc(1);
        cond_changed <= 1'b0;
        cyc(1);
        `CHK(init_setting_done_flag, 1'b1)
        init_setting_request <= 1'b0;
        cyc(2);
        `CHK(init_setting_done_flag, 1'b0)
        ch_operating <= 4'h2;
        cyc(1);
        init_setting_request <= 1'b1;
        cyc(2);
        `CHK({error_flag, remote_ready_flag, params_apply}, 3'b100)
        rchk(16'h1c00, 32'h0000_0003);
        rchk(16'h1c04, 32'h0000_ffff);
        init_setting_request <= 1'b0;
        ch_operating <= 4'h0;
        error_clear_request <= 1'b1;
        cyc(1);
        error_clear_request <= 1'b0;
        cyc(2);
        `CHK({error_flag, remote_ready_flag}, 2'b01)
        rchk(16'h1c08, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            error_event <= 1'b1;
            error_event_code <= i ? 16'h0010 : `TCRF_ERR_SETTING;
            cyc(1);
            error_event <= 1'b0;
            error_clear_request <= 1'b1;
            cyc(1);
            error_clear_request <= 1'b0;
            cyc(2);
            `CHK(error_flag, i[0])
        end
        apb(1'b1, 16'h4000, 32'h0000_0001);
        rchk(16'h1c08, 32'h0000_0000);
        test_done;
    end
endmodule
`default_nettype wire
